/* File: src/nal_pkg.sv */
// Constants, opcode encodings and types of the nibble accumulator logic unit.
package nal_pkg;

    localparam int unsigned NAL_DW       = 4;
    localparam int unsigned NAL_IW       = 10;
    localparam int unsigned NAL_RF_DEPTH = 32;
    localparam int unsigned NAL_RF_AW    = 5;
    localparam int unsigned NAL_PORTS    = 8;
    localparam int unsigned NAL_PAGE_W   = 2;

    // Instruction word fields.
    localparam int unsigned NAL_GRP_HI   = 9;
    localparam int unsigned NAL_GRP_LO   = 6;
    localparam int unsigned NAL_BANK_BIT = 5;
    localparam int unsigned NAL_SEL_BIT  = 5;

    // Opcode groups in word bits 9 to 6.
    localparam logic [3:0] NAL_GRP_AND = 4'hd;
    localparam logic [3:0] NAL_GRP_OR  = 4'hc;
    localparam logic [3:0] NAL_GRP_XOR = 4'ha;
    localparam logic [3:0] NAL_GRP_ROT = 4'he;
    localparam logic [3:0] NAL_GRP_IN  = 4'hf;
    localparam logic [3:0] NAL_GRP_OUT = 4'h2;

    // Operand selectors in word bits 4 to 0.
    localparam logic [4:0] NAL_SUB_ROM = 5'h10;
    localparam logic [4:0] NAL_SUB_IMM = 5'h11;
    localparam logic [4:0] NAL_SUB_INC = 5'h13;
    localparam logic [1:0] NAL_SUB_PRT = 2'h3;

    // Whole fixed words.
    localparam logic [9:0] NAL_W_INC = 10'h293;
    localparam logic [9:0] NAL_W_ROTL = 10'h393;
    localparam logic [9:0] NAL_W_ROTZ = 10'h3b3;

    // Pointer registers for program memory reads: pair 1/0 index 0.
    localparam logic [4:0] NAL_PTR_LO = 5'h00;
    localparam logic [4:0] NAL_PTR_HI = 5'h10;

    localparam logic [3:0]  NAL_ACC_RST   = 4'h0;
    localparam logic        NAL_CARRY_RST = 1'b0;
    localparam logic [1:0]  NAL_PAGE_RST  = 2'h0;
    localparam logic [3:0]  NAL_NIB_RST   = 4'h0;
    localparam logic [31:0] NAL_PORT_RST  = 32'h0000_0000;
    localparam logic [3:0]  NAL_ONE       = 4'h1;
    localparam logic [2:0]  NAL_SYNC_RST  = 3'h0;

    typedef enum logic [3:0] {
        NAL_OP_NONE,
        NAL_OP_AND,
        NAL_OP_OR,
        NAL_OP_XOR,
        NAL_OP_INC,
        NAL_OP_ROTL,
        NAL_OP_ROTZ,
        NAL_OP_IN,
        NAL_OP_OUT
    } nal_op_t;

    typedef enum logic [1:0] {
        NAL_SRC_REG,
        NAL_SRC_ROM,
        NAL_SRC_IMM,
        NAL_SRC_PORT
    } nal_src_t;

endpackage

/* File: src/nal_port_if.sv */
// Carrier of synchronised port pin data between the synchroniser and the core.
`timescale 1ns/10ps
interface nal_port_if;
    logic [31:0] port_data;
    modport src (output port_data);
    modport dst (input  port_data);
endinterface

/* File: src/nal_sync.sv */
// Three-stage pin synchroniser that accepts a bit once stages two and three agree.
`timescale 1ns/10ps
module nal_sync
    import nal_pkg::*;
#(
    parameter int unsigned WIDTH = 32
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic [WIDTH-1:0] pin_in,
    nal_port_if.src         sync_out
);

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic [2:0] stage_q;
            logic       stable_q;
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    stage_q  <= NAL_SYNC_RST;
                    stable_q <= 1'b0;
                end else begin
                    stage_q <= {stage_q[1:0], pin_in[gi]};
                    if (stage_q[1] == stage_q[2]) begin
                        stable_q <= stage_q[2];
                    end
                end
            end
            assign sync_out.port_data[gi] = stable_q;
        end
    endgenerate

endmodule // nal_sync

/* File: src/nal_core.sv */
// Four-bit accumulator datapath running logic, rotate, increment and port instructions.
`timescale 1ns/10ps
module nal_core
    import nal_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        instr_valid,
    input  wire logic [9:0]  instr_word,
    input  wire logic [9:0]  instr_data,
    input  wire logic [9:0]  rom_data,
    input  wire logic        page_wr,
    input  wire logic [1:0]  page_data,
    input  wire logic        reg_wr,
    input  wire logic [4:0]  reg_wr_addr,
    input  wire logic [3:0]  reg_wr_data,
    input  wire logic [31:0] port_pin_in,
    output logic [3:0]       acc,
    output logic             carry_flag,
    output logic [9:0]       rom_addr,
    output logic [31:0]      port_out,
    output logic             internal_reset
);

    logic [3:0]  acc_q;
    logic [3:0]  acc_d;
    logic        carry_q;
    logic        carry_d;
    logic [1:0]  rom_page_register_q;
    logic [3:0]  rf_q [NAL_RF_DEPTH];
    logic [31:0] port_out_q;
    logic        ireset_q;
    logic        ireset_d;
    nal_op_t     op;
    nal_src_t    src;

    nal_port_if port_bus ();

    nal_sync #(
        .WIDTH (32)
    ) u_sync (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .pin_in   (port_pin_in),
        .sync_out (port_bus.src)
    );

    // Field decode.
    wire [3:0] grp      = instr_word[NAL_GRP_HI:NAL_GRP_LO];
    wire [4:0] sub      = instr_word[4:0];
    wire       is_reg   = ~instr_word[4];
    wire       is_rom   = (sub == NAL_SUB_ROM);
    wire       is_imm   = (sub == NAL_SUB_IMM) && instr_word[NAL_SEL_BIT];
    wire       is_prt   = (instr_word[4:3] == NAL_SUB_PRT);
    wire [2:0] pn       = instr_word[2:0];
    wire       pn_ok    = (pn == 3'h0) || (pn == 3'h1) || (pn == 3'h3) || (pn == 3'h4);
    wire [1:0] pn_slot  = (pn == 3'h0) ? 2'h0 :
                          (pn == 3'h1) ? 2'h1 :
                          (pn == 3'h3) ? 2'h2 : 2'h3;
    wire [2:0] port_idx = {instr_word[NAL_BANK_BIT], pn_slot};
    wire [4:0] reg_idx  = {instr_word[NAL_BANK_BIT], instr_word[3:0]};

    // Operand selection.
    wire [3:0] reg_nib  = rf_q[reg_idx];
    wire [3:0] rom_nib  = instr_word[NAL_SEL_BIT] ? rom_data[3:0] : rom_data[7:4];
    wire [3:0] imm_nib  = instr_data[3:0];
    wire [3:0] prt_nib  = port_bus.port_data[{port_idx, 2'b00} +: 4];
    wire [3:0] opnd     = (src == NAL_SRC_REG) ? reg_nib :
                          (src == NAL_SRC_ROM) ? rom_nib :
                          (src == NAL_SRC_IMM) ? imm_nib : prt_nib;
    wire       a3_and   = acc_q[3] & opnd[3];
    wire [3:0] acc_inc  = acc_q + NAL_ONE;
    wire [3:0] acc_rot  = {acc_q[2:0], acc_q[3]};
    wire       acc_zero = (acc_q == NAL_ACC_RST);

    // Program memory address from page register and pointer pair.
    assign rom_addr = {rom_page_register_q, rf_q[NAL_PTR_HI], rf_q[NAL_PTR_LO]};

    always_comb begin
        op  = NAL_OP_NONE;
        src = NAL_SRC_REG;
        if (instr_valid) begin
            if (instr_word == NAL_W_INC) begin
                op = NAL_OP_INC;
            end else if (instr_word == NAL_W_ROTL) begin
                op = NAL_OP_ROTL;
            end else if (instr_word == NAL_W_ROTZ) begin
                op = NAL_OP_ROTZ;
            end else if (is_prt) begin
                src = NAL_SRC_PORT;
                if (pn_ok) begin
                    case (grp)
                        NAL_GRP_AND: op = NAL_OP_AND;
                        NAL_GRP_OR:  op = NAL_OP_OR;
                        NAL_GRP_IN:  op = NAL_OP_IN;
                        NAL_GRP_OUT: op = NAL_OP_OUT;
                        default:     op = NAL_OP_NONE;
                    endcase
                end
            end else if (is_reg || is_rom || is_imm) begin
                src = is_reg ? NAL_SRC_REG : (is_rom ? NAL_SRC_ROM : NAL_SRC_IMM);
                case (grp)
                    NAL_GRP_AND: op = NAL_OP_AND;
                    NAL_GRP_OR:  op = is_imm ? NAL_OP_NONE : NAL_OP_OR;
                    NAL_GRP_XOR: op = NAL_OP_XOR;
                    default:     op = NAL_OP_NONE;
                endcase
            end
        end
    end

    always_comb begin
        acc_d    = acc_q;
        carry_d  = carry_q;
        ireset_d = 1'b0;
        case (op)
            NAL_OP_AND: begin
                acc_d   = acc_q & opnd;
                carry_d = a3_and;
            end
            NAL_OP_OR: begin
                acc_d   = acc_q | opnd;
                carry_d = (src == NAL_SRC_PORT) ? carry_q : 1'b0;
            end
            NAL_OP_XOR: begin
                acc_d   = acc_q ^ opnd;
                carry_d = a3_and;
            end
            NAL_OP_INC: begin
                acc_d   = acc_inc;
                carry_d = (acc_inc == NAL_ACC_RST);
            end
            NAL_OP_ROTL: begin
                acc_d   = acc_rot;
                carry_d = acc_q[3];
            end
            NAL_OP_ROTZ: begin
                if (acc_zero) begin
                    acc_d    = NAL_ACC_RST;
                    carry_d  = NAL_CARRY_RST;
                    ireset_d = 1'b1;
                end else begin
                    acc_d   = acc_rot;
                    carry_d = acc_q[3];
                end
            end
            NAL_OP_IN: begin
                acc_d = prt_nib;
            end
            default: begin
                acc_d = acc_q;
            end
        endcase
    end

    // The internal reset clears state on the same edge, so the next word sees reset state.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q    <= NAL_ACC_RST;
            carry_q  <= NAL_CARRY_RST;
            ireset_q <= 1'b0;
        end else begin
            acc_q    <= acc_d;
            carry_q  <= carry_d;
            ireset_q <= ireset_d;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rom_page_register_q <= NAL_PAGE_RST;
        end else if (ireset_d) begin
            rom_page_register_q <= NAL_PAGE_RST;
        end else if (page_wr) begin
            rom_page_register_q <= page_data;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            port_out_q <= NAL_PORT_RST;
        end else if (ireset_d) begin
            port_out_q <= NAL_PORT_RST;
        end else if (op == NAL_OP_OUT) begin
            port_out_q[{port_idx, 2'b00} +: 4] <= acc_q;
        end
    end

    genvar gr;
    generate
        for (gr = 0; gr < NAL_RF_DEPTH; gr++) begin : g_rf
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    rf_q[gr] <= NAL_NIB_RST;
                end else if (ireset_d) begin
                    rf_q[gr] <= NAL_NIB_RST;
                end else if (reg_wr && (reg_wr_addr == 5'(gr))) begin
                    rf_q[gr] <= reg_wr_data;
                end
            end
        end
    endgenerate

    assign acc            = acc_q;
    assign carry_flag     = carry_q;
    assign port_out       = port_out_q;
    assign internal_reset = ireset_q;

endmodule // nal_core

/* File: verif/nal_monitor.sv */
// Concurrent checks on the accumulator unit's ports.
`timescale 1ns/10ps
module nal_monitor
    import nal_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        instr_valid,
    input wire logic [9:0]  instr_word,
    input wire logic [9:0]  instr_data,
    input wire logic [9:0]  rom_data,
    input wire logic        page_wr,
    input wire logic [1:0]  page_data,
    input wire logic [3:0]  acc,
    input wire logic        carry_flag,
    input wire logic [9:0]  rom_addr,
    input wire logic [31:0] port_out,
    input wire logic        internal_reset
);
    wire logic [3:0] grp = instr_word[9:6];
    wire logic       rom = instr_valid && instr_word[4:0] == NAL_SUB_ROM;
    wire logic       imm = instr_valid && instr_word[5:0] == {1'b1, NAL_SUB_IMM};
    wire logic [3:0] rn  = instr_word[5] ? rom_data[3:0] : rom_data[7:4];
    wire logic [3:0] k   = instr_data[3:0];
    wire logic       zr  = instr_valid && instr_word == NAL_W_ROTZ && acc == 4'h0;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    and_rom_a: assert property (rom && grp == NAL_GRP_AND |=> acc == $past(acc & rn)
        && carry_flag == $past(acc[3] & rn[3])) else $error("rom and result wrong");
    or_rom_a: assert property (rom && grp == NAL_GRP_OR |=> acc == $past(acc | rn)
        && !carry_flag) else $error("rom or result wrong");
    xor_rom_a: assert property (rom && grp == NAL_GRP_XOR |=> acc == $past(acc ^ rn)
        && carry_flag == $past(acc[3] & rn[3])) else $error("rom xor result wrong");
    and_imm_a: assert property (imm && grp == NAL_GRP_AND |=> acc == $past(acc & k)
        && carry_flag == $past(acc[3] & k[3])) else $error("immediate and wrong");
    xor_imm_a: assert property (imm && grp == NAL_GRP_XOR |=> acc == $past(acc ^ k)
        && carry_flag == $past(acc[3] & k[3])) else $error("immediate xor wrong");
    inc_wrap_a: assert property (instr_valid && instr_word == NAL_W_INC
        |=> acc == $past(acc) + 4'h1 && carry_flag == ($past(acc) == 4'hf))
        else $error("increment wrong");
    rotate_left_a: assert property (instr_valid && (instr_word == NAL_W_ROTL
        || (instr_word == NAL_W_ROTZ && acc != 4'h0)) |=> acc == {$past(acc[2:0]), $past(acc[3])}
        && carry_flag == $past(acc[3])) else $error("rotate wrong");
    zero_reset_a: assert property (zr |=> internal_reset && acc == 4'h0
        && !carry_flag && port_out == 32'h0 && rom_addr == 10'h0) else $error("reset missing");
    pulse_cause_a: assert property (!zr |=> !internal_reset)
        else $error("stray reset pulse");
    out_hold_a: assert property (!(instr_valid && grp == NAL_GRP_OUT) && !zr
        |=> $stable(port_out)) else $error("port latch changed");
    page_addr_a: assert property (page_wr && !zr |=> rom_addr[9:8] == $past(page_data))
        else $error("page bits wrong");
endmodule // nal_monitor
bind nal_core nal_monitor nal_monitor_inst (.*);

/* File: verif/nal_mem_model.sv */
// Program memory and port pin model on the far side of the unit.
`timescale 1ns/10ps
module nal_mem_model (
    input  wire logic [9:0]  rom_addr,
    input  wire logic [31:0] pin_val,
    output logic [9:0]       rom_data,
    output logic [31:0]      port_pin_in
);
    // Words scramble the address so that every nibble and bits 9 and 8 vary.
    assign rom_data    = {rom_addr[4:0], rom_addr[9:5]} ^ 10'h2d6;
    assign port_pin_in = pin_val;
endmodule // nal_mem_model

/* File: verif/nal_core_tb.sv */
// Self-checking testbench of the accumulator unit.
`timescale 1ns/10ps
module nal_core_tb
    import nal_pkg::*;
;
    logic mclk, rst_n, instr_valid, page_wr, reg_wr, m_carry, m_ir;
    logic [9:0]  instr_word, instr_data;
    logic [1:0]  page_data, m_page;
    logic [4:0]  reg_wr_addr;
    logic [3:0]  reg_wr_data, m_acc;
    logic [3:0]  m_reg [32];
    logic [31:0] pin_val, m_port, r;
    wire logic [9:0]  rom_data, rom_addr;
    wire logic [31:0] port_pin_in, port_out;
    wire logic [3:0]  acc;
    wire logic        carry_flag, internal_reset;
    int n_mismatch, num_checks;
    nal_core nal_core_inst (.mclk(mclk), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr_word(instr_word), .instr_data(instr_data), .rom_data(rom_data),
        .page_wr(page_wr), .page_data(page_data), .reg_wr(reg_wr), .reg_wr_addr(reg_wr_addr),
        .reg_wr_data(reg_wr_data), .port_pin_in(port_pin_in), .acc(acc),
        .carry_flag(carry_flag), .rom_addr(rom_addr), .port_out(port_out),
        .internal_reset(internal_reset));
    nal_mem_model nal_mem_model_inst (.rom_addr(rom_addr), .pin_val(pin_val),
        .rom_data(rom_data), .port_pin_in(port_pin_in));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task chk_acc(input logic [3:0] got, input logic [3:0] exp);
        chk(32'(got), 32'(exp));
    endtask
    task chk_bit(input logic got, input logic exp);
        chk(32'(got), 32'(exp));
    endtask
    function automatic logic [9:0] rom_fn(input logic [9:0] a);
        return {a[4:0], a[9:5]} ^ 10'h2d6;
    endfunction
    task clr;
        m_acc = 4'h0; m_carry = 1'b0; m_page = 2'h0; m_port = 32'h0;
        foreach (m_reg[i]) m_reg[i] = 4'h0;
    endtask
    task automatic model(input logic [9:0] w, input logic [9:0] d);
        logic [9:0] rw;
        logic [3:0] op, n;
        logic [2:0] s;
        logic c, ok, pt;
        rw = rom_fn({m_page, m_reg[16], m_reg[0]});
        s = (w[2:0] == 3'h4) ? 3'h3 : (w[2:0] == 3'h3) ? 3'h2 : w[2:0];
        pt = w[4:3] == 2'b11 && w[2:0] inside {3'h0, 3'h1, 3'h3, 3'h4};
        op = !w[4] ? m_reg[{w[5], w[3:0]}] : w[3] ? pin_val[{w[5], s[1:0]} * 4 +: 4]
           : w[0] ? d[3:0] : w[5] ? rw[3:0] : rw[7:4];
        ok = !w[4] || w[4:0] == 5'h10 || (w[5:0] == 6'h31) || pt;
        n = m_acc; c = m_carry; m_ir = 1'b0;
        if (w == NAL_W_INC) begin n = m_acc + 4'h1; c = n == 4'h0; ok = 1'b1; end
        else if (w == NAL_W_ROTZ && m_acc == 4'h0) begin clr(); m_ir = 1'b1; return; end
        else if (w == NAL_W_ROTL || w == NAL_W_ROTZ) begin
            n = {m_acc[2:0], m_acc[3]}; c = m_acc[3]; ok = 1'b1;
        end else case (w[9:6])
            NAL_GRP_AND: begin n = m_acc & op; c = m_acc[3] & op[3]; end
            NAL_GRP_OR: begin n = m_acc | op; c = pt & m_carry; ok = ok && w[5:0] != 6'h31; end
            NAL_GRP_XOR: begin n = m_acc ^ op; c = m_acc[3] & op[3]; ok = ok && !pt; end
            NAL_GRP_IN: begin n = op; ok = pt; end
            NAL_GRP_OUT: begin ok = pt; if (pt) m_port[{w[5], s[1:0]} * 4 +: 4] = m_acc; end
            default: ok = 1'b0;
        endcase
        if (ok) begin m_acc = n; m_carry = c; end
    endtask
    task run(input logic [9:0] w, input logic [9:0] d);
        instr_valid = 1'b1; reg_wr = 1'b0; page_wr = 1'b0; instr_word = w; instr_data = d;
        @(negedge mclk);
        model(w, d);
        chk_acc(acc, m_acc);
        chk_bit(carry_flag, m_carry);
        chk_bit(internal_reset, m_ir);
        chk(port_out, m_port);
    endtask
    task wr(input logic [4:0] a, input logic [3:0] v, input logic p);
        instr_valid = 1'b0; reg_wr = !p; page_wr = p; reg_wr_addr = a; reg_wr_data = v;
        page_data = v[1:0];
        @(negedge mclk);
        if (p) m_page = v[1:0];
        else m_reg[a] = v;
        m_ir = 1'b0;
        chk(32'(rom_addr), 32'({m_page, m_reg[16], m_reg[0]}));
    endtask
    task idle(input int n);
        instr_valid = 1'b0; reg_wr = 1'b0; page_wr = 1'b0;
        repeat (n) @(negedge mclk);
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        complete_run();
    end
    initial begin
        logic [3:0] gt [8];
        logic [9:0] wl [4];
        logic [9:0] wd;
        gt = '{NAL_GRP_AND, NAL_GRP_OR, NAL_GRP_XOR, NAL_GRP_IN, NAL_GRP_OUT, NAL_GRP_AND,
               NAL_GRP_XOR, NAL_GRP_OR};
        wl = '{NAL_W_INC, NAL_W_ROTL, NAL_W_ROTZ, 10'h331};
        rst_n = 1'b0; instr_valid = 1'b0; instr_word = 10'h0; instr_data = 10'h0;
        page_wr = 1'b0; page_data = 2'h0; reg_wr = 1'b0; reg_wr_addr = 5'h0;
        reg_wr_data = 4'h0; pin_val = 32'h0; n_mismatch = 0; num_checks = 0;
        clr(); m_ir = 1'b0;
        repeat (6) @(negedge mclk);
        rst_n = 1'b1;
        r = $urandom(64734);
        run(10'h2b1, 10'h00f);
        run(NAL_W_INC, 10'h0);
        run(NAL_W_ROTZ, 10'h0);
        run(NAL_W_INC, 10'h0);
        $display("test directed done");
        for (int i = 0; i < 400; i++) begin
            r = $urandom;
            wd = (r[6:4] == 3'h7) ? wl[r[9:8]] : (r[9:8] == 2'h0) ? {gt[r[6:4]], r[10], 1'b0,
                 r[14:11]} : (r[9:8] == 2'h1) ? {gt[r[6:4]], r[10], 5'h10}
                 : (r[9:8] == 2'h2) ? {gt[r[6:4]], 6'h31} : {gt[r[6:4]], r[10], 2'b11, r[13:11]};
            if (r[3:0] < 4'h3) wr(r[20:16], r[24:21], r[3:0] == 4'h2);
            else if (r[3:0] == 4'h3) begin
                pin_val = $urandom;
                idle(6);
            end else run(wd, r[25:16]);
        end
        $display("test random done");
        complete_run();
    end
endmodule // nal_core_tb
